// ==== ddec_ctrl_map.vh ====
// How it works
// RULE1 - Auto mode: burst below threshold kills chroma
// RULE2 - Restore chroma above threshold plus hysteresis
// RULE3 - Auto mode: no standard recognised blanks colour
// RULE4 - Skin phase bit: 117 clear, 123 set
// RULE5 - Skin correction only when enable set
// RULE6 - Four-bit slice fraction, blank to tip
// RULE7 - Green boost: composite, NTSC, active line
// RULE8 - Green gain 1.2 on axis, 1 beyond
// RULE9 - Signed tint rotates RGB-path Cr/Cb
// RULE10 - Signed luma/chroma skew in quarter periods
// RULE11 - Sat count limit 1+4pt+16ln lowers gain
// RULE12 - Luma below 772+8thr raises gain
// RULE13 - Luma above 807+8thr lowers gain
// RULE14 - Rate filter skips mismatched table entries
// RULE15 - Confirm field count decoded from code
// RULE16 - Overload bypass holds factor at one
// RULE17 - Burst bypass holds scale factor at one
// RULE18 - Notch width narrowest 000, widest 111
// RULE19 - Host writes reserved bits as prescribed
// RULE20 - Host should set confirm register bit 7
// RULE21 - Kill level acts only in mode 11
// RULE22 - Writes applied synchronously, reset defaults
`ifndef DDEC_CTRL_MAP_VH
`define DDEC_CTRL_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define KILL_MODE_ADDR 8'h0d
`define KILL_LVL_ADDR 8'h0f
`define SKIN_ADDR 8'h10
`define SLICE_ADDR 8'h11
`define GREEN_TINT_ADDR 8'h12
`define RSVD_A_ADDR 8'h13
`define RSVD_B_ADDR 8'h14
`define SKEW_ADDR 8'h15
`define AGC_ADDR 8'h16
`define CONFIRM_ADDR 8'h17
`define SEPAR_ADDR 8'h18

// ****************************************
// Reset values
// ****************************************
`define KILL_MODE_RST 8'h34
`define KILL_LVL_RST 8'h00
`define SKIN_RST 8'h10
`define SLICE_RST 8'h88
`define GREEN_TINT_RST 8'h00
`define RSVD_RST 8'h00
`define SKEW_RST 8'h10
`define AGC_RST 8'h7a
`define CONFIRM_RST 8'h24
`define SEPAR_RST 8'h59

// ****************************************
// Field positions and codes
// ****************************************
`define KILL_MODE_AUTO_BURST 2'h3
`define SKIN_PH_BIT 7
`define SKIN_EN_BIT 6
`define GREEN_EN_BIT 5
`define RATE_FILT_BIT 5
`define OVL_BYP_BIT 1
`define ACC_BYP_BIT 0
`define CONF_CODE_MSB 4
`define CONF_CODE_LSB 2
`define SAT_BASE 10'h001
`define LOW_LUMA_BASE 10'h304
`define HIGH_LUMA_BASE 10'h327
`define SKIN_ANG_CLR 8'h75
`define SKIN_ANG_SET 8'h7b

`endif

// ==== chroma_kill_hyst.v ====
`timescale 1ns/1ns
`default_nettype none
`include "ddec_ctrl_map.vh"

// Chroma-kill decision with hysteresis on burst amplitude
module chroma_kill_hyst (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Settings
    input wire [1:0] kill_mode_in,
    input wire [7:0] kill_lvl_in,
    // Datapath status
    input wire std_found_in,
    input wire [7:0] burst_amp_in,
    // Result
    output reg kill_out
);
    // ****************************************
    // Hysteresis state
    // ****************************************
    reg burst_low_q; // Burst currently judged too small
    reg burst_low_d;
    wire [8:0] thr = {4'h0, kill_lvl_in[4:0]};
    wire [8:0] up_thr = thr + {6'h00, kill_lvl_in[7:5]};
    wire [8:0] amp = {1'b0, burst_amp_in};

    // Kill below threshold, release above threshold plus hysteresis
    always @* begin
        burst_low_d = burst_low_q;
        if (!burst_low_q && amp < thr) begin
            burst_low_d = 1'b1; // RULE1
        end else if (burst_low_q && amp > up_thr) begin
            burst_low_d = 1'b0; // RULE2
        end
    end

    // Mode 00/11 automatic, 10 always killed, 01 never killed
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            burst_low_q <= 1'b0;
            kill_out <= 1'b1;
        end else begin
            burst_low_q <= burst_low_d;
            case (kill_mode_in)
                2'h1: kill_out <= 1'b0;
                2'h2: kill_out <= 1'b1;
                2'h0: kill_out <= !std_found_in; // RULE3
                default: kill_out <= !std_found_in || burst_low_d; // RULE21
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== confirm_counter.v ====
`timescale 1ns/1ns
`default_nettype none
`include "ddec_ctrl_map.vh"

// Confirmation stage: counts consecutive good fields
module confirm_counter (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Settings
    input wire [2:0] confirm_code_in,
    // Field events
    input wire field_end_in,
    input wire field_good_in,
    // Result
    output reg confirmed_out
);
    // ****************************************
    // Code to field count
    // ****************************************
    function [5:0] fields_needed;
        input [2:0] code;
        begin
            case (code)
                3'h0: fields_needed = 6'h01;
                3'h1: fields_needed = 6'h03;
                3'h2: fields_needed = 6'h07;
                3'h3: fields_needed = 6'h0a;
                3'h4: fields_needed = 6'h08;
                3'h5: fields_needed = 6'h20;
                3'h6: fields_needed = 6'h2d;
                default: fields_needed = 6'h3f;
            endcase
        end
    endfunction

    reg [5:0] good_cnt_q; // Consecutive good fields so far

    // A bad field restarts the run; count saturates at target
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            good_cnt_q <= 6'h00;
            confirmed_out <= 1'b0;
        end else if (field_end_in) begin
            if (!field_good_in) begin
                good_cnt_q <= 6'h00;
                confirmed_out <= 1'b0;
            end else if ({1'b0, good_cnt_q} + 7'h01 >=
                         {1'b0, fields_needed(confirm_code_in)}) begin
                // Seven-bit sum, so a count held at 63 cannot wrap
                good_cnt_q <= fields_needed(confirm_code_in);
                confirmed_out <= 1'b1; // RULE15
            end else begin
                good_cnt_q <= good_cnt_q + 6'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ==== ddec_ctrl_bank.v ====
`timescale 1ns/1ns
`default_nettype none
`include "ddec_ctrl_map.vh"

// Control bank for chroma, sync, AGC and standard-identification settings
module ddec_ctrl_bank (
    // Clock and reset
    input wire SYS_CLK_IN,
    input wire RESET_N_IN,
    // Register port from the control-bus decoder
    input wire REG_WR_IN,
    input wire REG_RD_IN,
    input wire [7:0] REG_ADDR_IN,
    input wire [7:0] REG_WDATA_IN,
    output reg [7:0] REG_RDATA_OUT,
    // Datapath status
    input wire STD_FOUND_IN,
    input wire [7:0] BURST_AMP_IN,
    input wire FIELD_END_IN,
    input wire FIELD_GOOD_IN,
    input wire [9:0] LUMA_IN,
    input wire [5:0] SAT_COUNT_IN,
    input wire ENTRY_IS_60HZ_IN,
    input wire DETECTED_60HZ_IN,
    input wire STD_IS_NTSC_IN,
    input wire CVBS_PATH_IN,
    input wire ACTIVE_LINE_IN,
    // Datapath settings and decisions
    output reg CHROMA_KILL_OUT,
    output reg [7:0] SKIN_ANGLE_OUT,
    output reg SKIN_CORR_ON_OUT,
    output reg [3:0] SLICE_FRACTION_OUT,
    output reg GREEN_BOOST_ACT_OUT,
    output reg [4:0] RGB_TINT_OUT,
    output reg [3:0] LUMA_SKEW_OUT,
    output reg [9:0] SAT_LIMIT_OUT,
    output reg AGC_GAIN_UP_OUT,
    output reg AGC_GAIN_DOWN_OUT,
    output reg ENTRY_SKIP_OUT,
    output reg STD_CONFIRMED_OUT,
    output reg OVERLOAD_UNITY_OUT,
    output reg BURST_UNITY_OUT,
    output reg [2:0] NOTCH_WIDTH_OUT
);
    // ****************************************
    // Register storage
    // ****************************************
    reg [7:0] kill_mode_q; // Colour-kill mode and identification
    reg [7:0] kill_lvl_q; // Kill threshold and hysteresis
    reg [7:0] skin_q; // Skin-tone control
    reg [7:0] slice_q; // Hsync_slice_fraction
    reg [7:0] green_tint_q; // Green boost and tint
    reg [7:0] rsvd_a_q; // Reserved, stored only
    reg [7:0] rsvd_b_q; // Reserved, stored only
    reg [7:0] skew_q; // Luma/chroma skew
    reg [7:0] agc_q; // AGC thresholds
    // Layout: bit5 rate filter, [4:2] confirm code, bits 1/0 bypasses
    // Reset 0x24 thus gives filter on, three fields, no bypass
    reg [7:0] confirm_q; // Confirmation and gain bypasses
    reg [7:0] separ_q; // Separation and output control

    // Reserved bits are stored as written; host keeps them legal
    // RULE19 RULE20
    always @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            kill_mode_q <= `KILL_MODE_RST; // RULE22
            kill_lvl_q <= `KILL_LVL_RST;
            skin_q <= `SKIN_RST;
            slice_q <= `SLICE_RST;
            green_tint_q <= `GREEN_TINT_RST;
            rsvd_a_q <= `RSVD_RST;
            rsvd_b_q <= `RSVD_RST;
            skew_q <= `SKEW_RST;
            agc_q <= `AGC_RST;
            confirm_q <= `CONFIRM_RST;
            separ_q <= `SEPAR_RST;
        end else if (REG_WR_IN) begin
            if (REG_ADDR_IN == `KILL_MODE_ADDR) begin
                kill_mode_q <= REG_WDATA_IN; // RULE22
            end else if (REG_ADDR_IN == `KILL_LVL_ADDR) begin
                kill_lvl_q <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == `SKIN_ADDR) begin
                skin_q <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == `SLICE_ADDR) begin
                slice_q <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == `GREEN_TINT_ADDR) begin
                green_tint_q <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == `RSVD_A_ADDR) begin
                rsvd_a_q <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == `RSVD_B_ADDR) begin
                rsvd_b_q <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == `SKEW_ADDR) begin
                skew_q <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == `AGC_ADDR) begin
                agc_q <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == `CONFIRM_ADDR) begin
                confirm_q <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == `SEPAR_ADDR) begin
                separ_q <= REG_WDATA_IN;
            end
        end
    end

    // ****************************************
    // Read-back
    // ****************************************
    reg [7:0] rdata_d;

    // Unmapped addresses read as zero
    always @* begin
        rdata_d = 8'h00;
        if (REG_ADDR_IN == `KILL_MODE_ADDR) begin
            rdata_d = kill_mode_q;
        end else if (REG_ADDR_IN == `KILL_LVL_ADDR) begin
            rdata_d = kill_lvl_q;
        end else if (REG_ADDR_IN == `SKIN_ADDR) begin
            rdata_d = skin_q;
        end else if (REG_ADDR_IN == `SLICE_ADDR) begin
            rdata_d = slice_q;
        end else if (REG_ADDR_IN == `GREEN_TINT_ADDR) begin
            rdata_d = green_tint_q;
        end else if (REG_ADDR_IN == `RSVD_A_ADDR) begin
            rdata_d = rsvd_a_q;
        end else if (REG_ADDR_IN == `RSVD_B_ADDR) begin
            rdata_d = rsvd_b_q;
        end else if (REG_ADDR_IN == `SKEW_ADDR) begin
            rdata_d = skew_q;
        end else if (REG_ADDR_IN == `AGC_ADDR) begin
            rdata_d = agc_q;
        end else if (REG_ADDR_IN == `CONFIRM_ADDR) begin
            rdata_d = confirm_q;
        end else if (REG_ADDR_IN == `SEPAR_ADDR) begin
            rdata_d = separ_q;
        end
    end

    // Read data registered one cycle after the strobe
    always @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            REG_RDATA_OUT <= 8'h00;
        end else if (REG_RD_IN) begin
            REG_RDATA_OUT <= rdata_d;
        end
    end

    // ****************************************
    // Threshold arithmetic
    // ****************************************
    // Base plus two-bit field times eight
    function [9:0] luma_thr;
        input [9:0] base;
        input [1:0] fld;
        begin
            luma_thr = base + {5'h00, fld, 3'h0};
        end
    endfunction

    wire [9:0] sat_limit = `SAT_BASE + {6'h00, agc_q[5:4], 2'h0}
                         + {4'h0, agc_q[7:6], 4'h0}; // RULE11
    wire [9:0] low_thr = luma_thr(`LOW_LUMA_BASE, agc_q[3:2]);
    wire [9:0] high_thr = luma_thr(`HIGH_LUMA_BASE, agc_q[1:0]);

    // ****************************************
    // Sub-blocks
    // ****************************************
    wire kill_w; // Kill decision from the hysteresis unit
    wire confirmed_w; // Confirmation result

    chroma_kill_hyst u_kill (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RESET_N_IN),
        .kill_mode_in(kill_mode_q[1:0]),
        .kill_lvl_in(kill_lvl_q),
        .std_found_in(STD_FOUND_IN),
        .burst_amp_in(BURST_AMP_IN),
        .kill_out(kill_w)
    );

    confirm_counter u_confirm (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RESET_N_IN),
        .confirm_code_in(confirm_q[`CONF_CODE_MSB:`CONF_CODE_LSB]),
        .field_end_in(FIELD_END_IN),
        .field_good_in(FIELD_GOOD_IN),
        .confirmed_out(confirmed_w)
    );

    // ****************************************
    // Settings out to the datapath
    // ****************************************
    // Every output registered so the datapath sees clean levels
    always @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            CHROMA_KILL_OUT <= 1'b1;
            SKIN_ANGLE_OUT <= `SKIN_ANG_CLR;
            SKIN_CORR_ON_OUT <= 1'b0;
            SLICE_FRACTION_OUT <= 4'h8;
            GREEN_BOOST_ACT_OUT <= 1'b0;
            RGB_TINT_OUT <= 5'h00;
            LUMA_SKEW_OUT <= 4'h0;
            SAT_LIMIT_OUT <= 10'h000;
            AGC_GAIN_UP_OUT <= 1'b0;
            AGC_GAIN_DOWN_OUT <= 1'b0;
            ENTRY_SKIP_OUT <= 1'b0;
            STD_CONFIRMED_OUT <= 1'b0;
            OVERLOAD_UNITY_OUT <= 1'b0;
            BURST_UNITY_OUT <= 1'b0;
            NOTCH_WIDTH_OUT <= 3'h5;
        end else begin
            CHROMA_KILL_OUT <= kill_w; // RULE1
            SKIN_ANGLE_OUT <= skin_q[`SKIN_PH_BIT] ? `SKIN_ANG_SET
                                                  : `SKIN_ANG_CLR; // RULE4
            SKIN_CORR_ON_OUT <= skin_q[`SKIN_EN_BIT]; // RULE5
            SLICE_FRACTION_OUT <= slice_q[7:4]; // RULE6
            // Gain profile 1.2 to 1 is applied by the datapath
            GREEN_BOOST_ACT_OUT <= green_tint_q[`GREEN_EN_BIT]
                && CVBS_PATH_IN && STD_IS_NTSC_IN
                && ACTIVE_LINE_IN; // RULE7 RULE8
            RGB_TINT_OUT <= green_tint_q[4:0]; // RULE9
            LUMA_SKEW_OUT <= skew_q[3:0]; // RULE10
            SAT_LIMIT_OUT <= sat_limit;
            AGC_GAIN_UP_OUT <= LUMA_IN < low_thr; // RULE12
            AGC_GAIN_DOWN_OUT <= (LUMA_IN > high_thr)
                || ({4'h0, SAT_COUNT_IN} >= sat_limit); // RULE13 RULE11
            ENTRY_SKIP_OUT <= confirm_q[`RATE_FILT_BIT]
                && (ENTRY_IS_60HZ_IN != DETECTED_60HZ_IN); // RULE14
            STD_CONFIRMED_OUT <= confirmed_w; // RULE15
            OVERLOAD_UNITY_OUT <= confirm_q[`OVL_BYP_BIT]; // RULE16
            BURST_UNITY_OUT <= confirm_q[`ACC_BYP_BIT]; // RULE17
            NOTCH_WIDTH_OUT <= separ_q[6:4]; // RULE18
        end
    end
endmodule
`default_nettype wire

// ==== ddec_ctrl_bank_props.sv ====
`timescale 1ns/1ns
`default_nettype none
// Port-level timing checks for the control bank
module ddec_ctrl_bank_props (
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic RESET_N_IN,
    // Register port
    input wire logic REG_WR_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    // Datapath status
    input wire logic [9:0] LUMA_IN,
    input wire logic ENTRY_IS_60HZ_IN,
    input wire logic DETECTED_60HZ_IN,
    input wire logic STD_IS_NTSC_IN,
    input wire logic CVBS_PATH_IN,
    input wire logic ACTIVE_LINE_IN,
    // Settings and decisions
    input wire logic [7:0] SKIN_ANGLE_OUT,
    input wire logic SKIN_CORR_ON_OUT,
    input wire logic [3:0] SLICE_FRACTION_OUT,
    input wire logic GREEN_BOOST_ACT_OUT,
    input wire logic [9:0] SAT_LIMIT_OUT,
    input wire logic AGC_GAIN_UP_OUT,
    input wire logic AGC_GAIN_DOWN_OUT,
    input wire logic ENTRY_SKIP_OUT,
    input wire logic OVERLOAD_UNITY_OUT,
    input wire logic BURST_UNITY_OUT,
    input wire logic [2:0] NOTCH_WIDTH_OUT
);
    // ****************************************
    // Write decodes, two edges before effect
    // ****************************************
    wire w_skin = REG_WR_IN && REG_ADDR_IN == 8'h10;
    wire w_slice = REG_WR_IN && REG_ADDR_IN == 8'h11;
    wire w_agc = REG_WR_IN && REG_ADDR_IN == 8'h16;
    wire w_conf = REG_WR_IN && REG_ADDR_IN == 8'h17;
    wire w_sep = REG_WR_IN && REG_ADDR_IN == 8'h18;
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    skin_angle_a: assert property (w_skin |-> ##2 SKIN_ANGLE_OUT ==
        ($past(REG_WDATA_IN[7], 2) ? 8'h7b : 8'h75)) else $error("skin angle");
    skin_enable_a: assert property (w_skin |-> ##2
        SKIN_CORR_ON_OUT == $past(REG_WDATA_IN[6], 2)) else $error("skin on");
    slice_level_a: assert property (w_slice |-> ##2
        SLICE_FRACTION_OUT == $past(REG_WDATA_IN[7:4], 2)) else $error("slice");
    green_gate_a: assert property (GREEN_BOOST_ACT_OUT |->
        $past(CVBS_PATH_IN && STD_IS_NTSC_IN && ACTIVE_LINE_IN))
        else $error("green boost outside composite ntsc active line");
    sat_limit_a: assert property (w_agc |-> ##2 SAT_LIMIT_OUT ==
        10'd1 + {6'h0, $past(REG_WDATA_IN[5:4], 2), 2'h0}
        + {4'h0, $past(REG_WDATA_IN[7:6], 2), 4'h0}) else $error("sat limit");
    luma_low_a: assert property (LUMA_IN < 10'd772 |=>
        AGC_GAIN_UP_OUT) else $error("gain up missing");
    luma_high_a: assert property (LUMA_IN > 10'd831 |=>
        AGC_GAIN_DOWN_OUT) else $error("gain down missing");
    entry_skip_a: assert property (ENTRY_SKIP_OUT |->
        $past(ENTRY_IS_60HZ_IN != DETECTED_60HZ_IN)) else $error("bad skip");
    unity_bits_a: assert property (w_conf |-> ##2
        {OVERLOAD_UNITY_OUT, BURST_UNITY_OUT} == $past(REG_WDATA_IN[1:0], 2))
        else $error("unity bypass");
    notch_width_a: assert property (w_sep |-> ##2
        NOTCH_WIDTH_OUT == $past(REG_WDATA_IN[6:4], 2)) else $error("notch");
    // Main scenarios reached
    cover property (GREEN_BOOST_ACT_OUT);
    cover property (ENTRY_SKIP_OUT);
    cover property (AGC_GAIN_DOWN_OUT ##1 AGC_GAIN_UP_OUT);
endmodule
bind ddec_ctrl_bank ddec_ctrl_bank_props i_props (.*);
`default_nettype wire

// ==== reg_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Host software stand-in: single-byte accesses on the register port
module reg_host_model (
    // Clock and read data
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    // Register port requests
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out
);
    // Idle port at time zero
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end
    // One write, strobe held for exactly one taking edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        wr_out <= 1'b0;
    endtask
    // One read; data holds, so sample after the following edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        rd_out <= 1'b1;
        addr_out <= a;
        @(posedge clk_in);
        rd_out <= 1'b0;
        @(posedge clk_in);
        #1 d = rdata_in;
    endtask
    // Skin control with reserved low bits as prescribed
    task automatic wr_skin(input logic ph, input logic en);
        wr_reg(8'h10, {ph, en, 6'h10});
    endtask
    // Confirm register with bits 7 and 6 always set
    task automatic wr_confirm(input logic [5:0] d);
        wr_reg(8'h17, {2'b11, d});
    endtask
endmodule
`default_nettype wire

// ==== ddec_ctrl_bank_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ddec_ctrl_map.vh"
// Self-checking bench for the control bank
module ddec_ctrl_bank_bench;
    logic clk, rst_n, wr, rd, found, fend, fgood, e60, d60, ntsc, cvbs, act;
    logic [7:0] addr, wdata, rdata, amp, ang, rv;
    logic [9:0] luma, slim;
    logic [5:0] scnt;
    logic kill, skon, grn, up, dn, skip, conf, ovl, bst;
    logic [3:0] slice, skew;
    logic [4:0] tint;
    logic [2:0] notch;
    int n_mismatch, compares, cycles;
    reg_host_model i_host (.clk_in(clk), .rdata_in(rdata), .wr_out(wr),
        .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
    ddec_ctrl_bank i_dut (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .STD_FOUND_IN(found),
        .BURST_AMP_IN(amp), .FIELD_END_IN(fend), .FIELD_GOOD_IN(fgood),
        .LUMA_IN(luma), .SAT_COUNT_IN(scnt), .ENTRY_IS_60HZ_IN(e60),
        .DETECTED_60HZ_IN(d60), .STD_IS_NTSC_IN(ntsc), .CVBS_PATH_IN(cvbs),
        .ACTIVE_LINE_IN(act), .CHROMA_KILL_OUT(kill), .SKIN_ANGLE_OUT(ang),
        .SKIN_CORR_ON_OUT(skon), .SLICE_FRACTION_OUT(slice),
        .GREEN_BOOST_ACT_OUT(grn), .RGB_TINT_OUT(tint), .LUMA_SKEW_OUT(skew),
        .SAT_LIMIT_OUT(slim), .AGC_GAIN_UP_OUT(up), .AGC_GAIN_DOWN_OUT(dn),
        .ENTRY_SKIP_OUT(skip), .STD_CONFIRMED_OUT(conf),
        .OVERLOAD_UNITY_OUT(ovl), .BURST_UNITY_OUT(bst),
        .NOTCH_WIDTH_OUT(notch));
    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Kill path has two register stages, so allow three edges
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        logic [7:0] a [13] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12,
            8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h20};
        logic [7:0] e [13] = '{`KILL_MODE_RST, 8'h00, 8'h00, 8'h10, 8'h88,
            8'h00, 8'h00, 8'h00, 8'h10, 8'h7a, 8'h24, 8'h59, 8'h00};
        for (int i = 0; i < 13; i++) begin
            i_host.rd_reg(a[i], rv);
            chk("reset read", {2'h0, rv}, {2'h0, e[i]});
        end
        chk("default sat limit", slim, 10'd29);
        chk("reset outputs", {4'h0, ovl, bst, notch, skon}, 10'h00a);
    endtask
    task automatic t_skin();
        i_host.wr_skin(1'b1, 1'b1);
        settle();
        chk("angle set", {2'h0, ang}, 10'h07b);
        chk("skin on", {9'h0, skon}, 10'h001);
        i_host.wr_skin(1'b0, 1'b0);
        settle();
        chk("angle clear", {2'h0, ang}, 10'h075);
        chk("skin off", {9'h0, skon}, 10'h000);
    endtask
    // Writes to four registers, one idle cycle apart, then path gating
    task automatic t_fields();
        i_host.wr_reg(8'h11, 8'hf0);
        i_host.wr_reg(8'h12, 8'h30);
        i_host.wr_reg(8'h15, 8'h18);
        i_host.wr_reg(8'h18, 8'h70);
        @(posedge clk);
        {cvbs, ntsc, act} <= 3'b111;
        settle();
        chk("slice", {6'h0, slice}, 10'h00f);
        chk("tint", {5'h0, tint}, 10'h010);
        chk("skew", {6'h0, skew}, 10'h008);
        chk("notch", {7'h0, notch}, 10'h007);
        chk("green on", {9'h0, grn}, 10'h001);
        @(posedge clk);
        act <= 1'b0;
        settle();
        chk("green idle", {9'h0, grn}, 10'h000);
    endtask
    task automatic probe(input logic [9:0] l, input logic [5:0] s,
        input logic eu, input logic ed);
        @(posedge clk);
        luma <= l;
        scnt <= s;
        settle();
        chk("gain up", {9'h0, up}, {9'h0, eu});
        chk("gain down", {9'h0, dn}, {9'h0, ed});
    endtask
    task automatic t_agc(input logic [7:0] v);
        logic [9:0] lo, hi, lim;
        lo = 10'd772 + 10'd8 * v[3:2];
        hi = 10'd807 + 10'd8 * v[1:0];
        lim = 10'd1 + 10'd4 * v[5:4] + 10'd16 * v[7:6];
        i_host.wr_reg(8'h16, v);
        probe(lo - 10'd1, 6'h0, 1'b1, 1'b0);
        probe(lo, 6'h0, 1'b0, 1'b0);
        probe(hi + 10'd1, 6'h0, 1'b0, 1'b1);
        probe(hi, lim[5:0] - 6'h1, 1'b0, 1'b0);
        probe(hi, lim[5:0], 1'b0, 1'b1);
        chk("sat limit", slim, lim);
    endtask
    task automatic probe_k(input logic f, input logic [7:0] a, input logic e);
        @(posedge clk);
        found <= f;
        amp <= a;
        settle();
        chk("kill", {9'h0, kill}, {9'h0, e});
    endtask
    task automatic t_kill();
        i_host.wr_reg(8'h0d, 8'h17);
        i_host.wr_reg(8'h0f, 8'h48);
        probe_k(1'b1, 8'd20, 1'b0);
        probe_k(1'b1, 8'd7, 1'b1);
        probe_k(1'b1, 8'd10, 1'b1);
        probe_k(1'b1, 8'd11, 1'b0);
        probe_k(1'b0, 8'd20, 1'b1);
        i_host.wr_reg(8'h0d, 8'h14);
        probe_k(1'b1, 8'd7, 1'b0);
        i_host.wr_reg(8'h0d, 8'h15);
        probe_k(1'b0, 8'd7, 1'b0);
        i_host.wr_reg(8'h0d, 8'h16);
        probe_k(1'b1, 8'd20, 1'b1);
    endtask
    task automatic field(input logic g);
        @(posedge clk);
        fend <= 1'b1;
        fgood <= g;
        @(posedge clk);
        fend <= 1'b0;
    endtask
    task automatic t_confirm();
        int n [8] = '{1, 3, 7, 10, 8, 32, 45, 63};
        for (int c = 0; c < 8; c++) begin
            i_host.wr_confirm({1'b1, c[2:0], 2'b00});
            field(1'b0);
            repeat (n[c] - 1) field(1'b1);
            settle();
            chk("early confirm", {9'h0, conf}, 10'h000);
            field(1'b1);
            settle();
            chk("confirm", {9'h0, conf}, 10'h001);
        end
        @(posedge clk);
        {e60, d60} <= 2'b10;
        settle();
        chk("skip on", {9'h0, skip}, 10'h001);
        i_host.wr_confirm(6'h03);
        settle();
        chk("skip off", {9'h0, skip}, 10'h000);
        chk("unity", {8'h0, ovl, bst}, 10'h003);
    endtask
    // ****************************************
    // Clock, timeout and main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run needs well under ten thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        {rst_n, found, fend, fgood, e60, d60, ntsc, cvbs, act} = 9'h0;
        amp = 8'h00;
        luma = 10'd800;
        scnt = 6'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_skin();
        t_fields();
        t_agc(8'h00);
        t_agc(8'hff);
        t_kill();
        t_confirm();
        tally_and_finish();
    end
endmodule
`default_nettype wire
